// *** i2cic_pkg.sv ***
// package for the i2c interrupt-clear and controller-enable block
package i2cic_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] RX_DONE_CLR_ADDR = 32'h5000_1358;
  localparam logic [31:0] BUS_BUSY_CLR_ADDR = 32'h5000_135c;
  localparam logic [31:0] STOP_DET_CLR_ADDR = 32'h5000_1360;
  localparam logic [31:0] START_SEEN_FLAG_CLR_ADDR = 32'h5000_1364;
  localparam logic [31:0] BCAST_CLR_ADDR = 32'h5000_1368;
  localparam logic [31:0] ON_OFF_ADDR = 32'h5000_136c;
  localparam logic [31:0] RAW_STAT_ADDR = 32'h5000_13a0;
  localparam logic [31:0] IRQ_PEND_ADDR = 32'h5000_13a4;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_13a8;
  localparam logic [31:0] MASKED_STAT_ADDR = 32'h5000_13ac;

  // ----------------------------------------------------------------
  // field positions in the raw interrupt status word and the on/off register
  // ----------------------------------------------------------------
  localparam int RX_DONE_BIT = 7;
  localparam int BUS_BUSY_BIT = 8;
  localparam int STOP_DET_BIT = 9;
  localparam int START_SEEN_FLAG_BIT = 10;
  localparam int BCAST_BIT = 11;
  localparam int ON_OFF_BIT = 0;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int EVT_N = 5;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [4:0] IRQ_RESET = 5'h00;

  // pending and mask bit order: rx_done, busy, stop, start, bcast
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_BUS_BUSY = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_START = 3;
  localparam int IRQ_BCAST = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } i2cic_bus_t;

  typedef struct packed {
    logic rx_done;
    logic stop_seen;
    logic start_seen;
    logic bcast;
  } i2cic_evt_t;

  typedef struct packed {
    logic mst_active;
    logic slv_active;
    logic tx_busy;
    logic rx_busy;
    logic xfer_done;
    logic byte_done;
  } i2cic_core_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DRAIN_TX = 2'b01,
    ST_DRAIN_RX = 2'b10,
    ST_OFF = 2'b11
  } i2cic_state_t;

endpackage

// *** i2cic_top.sv ***
// interrupt-clear registers and controller enable sequencing for the i2c unit
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module i2cic_top
  import i2cic_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire i2cic_bus_t bus_in,
  output logic [15:0] rdata_out,
  input wire i2cic_evt_t evt_in,
  input wire i2cic_core_t core_in,
  output logic [15:0] raw_irq_status_out,
  output logic [15:0] masked_irq_status_out,
  output logic ctrl_enable_out,
  output logic tx_flush_out,
  output logic rx_flush_out,
  output logic stop_after_xfer_out,
  output logic nack_next_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n_reg;

  // two-stage release of the asynchronous reset
  // assertion stays asynchronous, release is aligned to the clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic rd_rx_done;
  logic rd_busy;
  logic rd_stop;
  logic rd_start;
  logic rd_bcast;
  logic wr_on_off;
  logic wr_pend;
  logic wr_mask;
  logic active;

  // read strobes of the clear registers and write strobes
  assign rd_rx_done = bus_in.rd && (bus_in.addr == RX_DONE_CLR_ADDR);
  assign rd_busy = bus_in.rd && (bus_in.addr == BUS_BUSY_CLR_ADDR);
  assign rd_stop = bus_in.rd && (bus_in.addr == STOP_DET_CLR_ADDR);
  assign rd_start = bus_in.rd && (bus_in.addr == START_SEEN_FLAG_CLR_ADDR);
  assign rd_bcast = bus_in.rd && (bus_in.addr == BCAST_CLR_ADDR);
  assign wr_on_off = bus_in.wr && (bus_in.addr == ON_OFF_ADDR);
  assign wr_pend = bus_in.wr && (bus_in.addr == IRQ_PEND_ADDR);
  assign wr_mask = bus_in.wr && (bus_in.addr == IRQ_MASK_ADDR);
  assign active = core_in.mst_active || core_in.slv_active;

  // ----------------------------------------------------------------
  // enable register and its two-cycle path
  // ----------------------------------------------------------------
  logic on_off_reg;
  logic en_d1_reg;
  logic en_eff_reg;

  // software enable bit, reset value zero
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      on_off_reg <= REG_RESET[ON_OFF_BIT];
    end else if (wr_on_off) begin
      on_off_reg <= bus_in.wdata[ON_OFF_BIT];
    end
  end

  // effective enable trails the register by two clocks
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      en_d1_reg <= 1'b0;
      en_eff_reg <= 1'b0;
    end else begin
      en_d1_reg <= on_off_reg;
      en_eff_reg <= en_d1_reg;
    end
  end

  // ----------------------------------------------------------------
  // disable sequencing
  // ----------------------------------------------------------------
  i2cic_state_t state_reg;
  i2cic_state_t state_next;

  // graceful shutdown of an active transfer
  // transmit drains to the end of its transfer, receive to the end of its byte
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (!en_eff_reg) begin
          if (core_in.tx_busy) begin
            state_next = ST_DRAIN_TX;
          end else if (core_in.rx_busy) begin
            state_next = ST_DRAIN_RX;
          end else begin
            state_next = ST_OFF;
          end
        end
      end
      ST_DRAIN_TX: begin
        if (core_in.xfer_done) begin
          state_next = ST_OFF;
        end
      end
      ST_DRAIN_RX: begin
        if (core_in.byte_done) begin
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        if (en_eff_reg) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // state register, comes up disabled
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // enable seen by the core, in step with the effective enable
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_enable_out <= 1'b0;
    end else begin
      ctrl_enable_out <= en_d1_reg;
    end
  end

  // receive fifo is held erased as soon as the enable drops
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_flush_out <= 1'b1;
    end else begin
      rx_flush_out <= !en_d1_reg;
    end
  end

  // transmit fifo is kept until a drain ends, so the last transfer can finish
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_flush_out <= 1'b1;
    end else begin
      tx_flush_out <= (state_next == ST_OFF);
    end
  end

  // stop request while a transmit drains
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      stop_after_xfer_out <= 1'b0;
    end else begin
      stop_after_xfer_out <= (state_next == ST_DRAIN_TX);
    end
  end

  // nack request while a receive drains
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      nack_next_out <= 1'b0;
    end else begin
      nack_next_out <= (state_next == ST_DRAIN_RX);
    end
  end

  // ----------------------------------------------------------------
  // raw interrupt flags
  // ----------------------------------------------------------------
  logic rx_done_reg;
  logic busy_reg;
  logic stop_reg;
  logic start_reg;
  logic bcast_reg;

  // read-to-clear flags; a new event in the clear cycle wins
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_done_reg <= 1'b0;
      stop_reg <= 1'b0;
      start_reg <= 1'b0;
      bcast_reg <= 1'b0;
    end else begin
      rx_done_reg <= evt_in.rx_done || (rx_done_reg && !rd_rx_done);
      stop_reg <= evt_in.stop_seen || (stop_reg && !rd_stop);
      start_reg <= evt_in.start_seen || (start_reg && !rd_start);
      bcast_reg <= evt_in.bcast || (bcast_reg && !rd_bcast);
    end
  end

  // busy flag set by bus activity, cleared by a read or while disabled and idle
  // activity wins over a clear read, so software cannot drop it mid-transfer
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      busy_reg <= 1'b0;
    end else if (active) begin
      busy_reg <= 1'b1;
    end else if (rd_busy) begin
      busy_reg <= 1'b0;
    end else if (!en_eff_reg) begin
      busy_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status views and interrupt
  // ----------------------------------------------------------------
  logic [15:0] raw_word;
  logic [4:0] ev_rise;
  logic [4:0] ev_now;
  logic [4:0] ev_last_reg;
  logic [4:0] pend_reg;
  logic [4:0] mask_reg;
  logic [15:0] mask_word;
  logic keep_masked;

  // raw word built from the flags
  always_comb begin
    raw_word = 16'h0000;
    raw_word[RX_DONE_BIT] = rx_done_reg;
    raw_word[BUS_BUSY_BIT] = busy_reg;
    raw_word[STOP_DET_BIT] = stop_reg;
    raw_word[START_SEEN_FLAG_BIT] = start_reg;
    raw_word[BCAST_BIT] = bcast_reg;
  end

  // mask spread onto the raw word layout
  always_comb begin
    mask_word = 16'h0000;
    mask_word[RX_DONE_BIT] = mask_reg[IRQ_RX_DONE];
    mask_word[BUS_BUSY_BIT] = mask_reg[IRQ_BUS_BUSY];
    mask_word[STOP_DET_BIT] = mask_reg[IRQ_STOP];
    mask_word[START_SEEN_FLAG_BIT] = mask_reg[IRQ_START];
    mask_word[BCAST_BIT] = mask_reg[IRQ_BCAST];
  end

  // masked view stays live until the state machine is idle
  // the drain can still raise flags that software must see
  assign keep_masked = en_eff_reg || (state_reg != ST_OFF) || active;

  // flag vector in pending order and its rising edges
  assign ev_now = {bcast_reg, start_reg, stop_reg, busy_reg, rx_done_reg};
  assign ev_rise = ev_now & ~ev_last_reg;

  // edge memory
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ev_last_reg <= IRQ_RESET;
    end else begin
      ev_last_reg <= ev_now;
    end
  end

  // sticky pending bits, write one to clear, set wins
  // an event in the clearing cycle is kept, so no edge is ever lost
  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi++) begin : g_pend
      always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          pend_reg[gi] <= IRQ_RESET[gi];
        end else if (ev_rise[gi]) begin
          pend_reg[gi] <= 1'b1;
        end else if (wr_pend && bus_in.wdata[gi]) begin
          pend_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt mask
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mask_reg <= IRQ_RESET;
    end else if (wr_mask) begin
      mask_reg <= bus_in.wdata[EVT_N-1:0];
    end
  end

  // registered copy of the raw flags
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      raw_irq_status_out <= REG_RESET;
    end else begin
      raw_irq_status_out <= raw_word;
    end
  end

  // masked view, cleared only once the shutdown is complete
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      masked_irq_status_out <= REG_RESET;
    end else begin
      masked_irq_status_out <= keep_masked ? (raw_word & mask_word) : REG_RESET;
    end
  end

  // level interrupt from unmasked pending bits
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(pend_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [15:0] rd_next;

  // read mux; clear registers return their flag in bit 0
  always_comb begin
    rd_next = 16'h0000;
    case (bus_in.addr)
      RX_DONE_CLR_ADDR: rd_next[0] = rx_done_reg;
      BUS_BUSY_CLR_ADDR: rd_next[0] = busy_reg;
      STOP_DET_CLR_ADDR: rd_next[0] = stop_reg;
      START_SEEN_FLAG_CLR_ADDR: rd_next[0] = start_reg;
      BCAST_CLR_ADDR: rd_next[0] = bcast_reg;
      ON_OFF_ADDR: rd_next[ON_OFF_BIT] = on_off_reg;
      RAW_STAT_ADDR: rd_next = raw_word;
      IRQ_PEND_ADDR: rd_next[EVT_N-1:0] = pend_reg;
      IRQ_MASK_ADDR: rd_next[EVT_N-1:0] = mask_reg;
      MASKED_STAT_ADDR: rd_next = keep_masked ? (raw_word & mask_word) : REG_RESET;
      default: rd_next = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  // a zero word outside that cycle keeps stale flags off the bus
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_out <= REG_RESET;
    end else if (bus_in.rd) begin
      rdata_out <= rd_next;
    end else begin
      rdata_out <= REG_RESET;
    end
  end

endmodule

// *** i2cic_monitor.sv ***
// concurrent checks on the ports of the interrupt-clear and enable block
`timescale 1ns/1ps
module i2cic_monitor
  import i2cic_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire i2cic_bus_t bus_in,
  input wire logic [15:0] rdata_out,
  input wire i2cic_evt_t evt_in,
  input wire i2cic_core_t core_in,
  input wire logic [15:0] raw_irq_status_out,
  input wire logic ctrl_enable_out,
  input wire logic tx_flush_out,
  input wire logic rx_flush_out,
  input wire logic stop_after_xfer_out,
  input wire logic nack_next_out
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_rx_clr;
    bus_in.rd && bus_in.addr == RX_DONE_CLR_ADDR && !evt_in.rx_done |-> ##2 !raw_irq_status_out[7]; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx done flag kept");
  property p_stop_clr;
    bus_in.rd && bus_in.addr == STOP_DET_CLR_ADDR && !evt_in.stop_seen |-> ##2 !raw_irq_status_out[9]; endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop flag kept");
  property p_start_clr;
    bus_in.rd && bus_in.addr == START_SEEN_FLAG_CLR_ADDR && !evt_in.start_seen |-> ##2 !raw_irq_status_out[10]; endproperty
  a_start_clr: assert property (p_start_clr) else $error("start flag kept");
  property p_bcast_clr;
    bus_in.rd && bus_in.addr == BCAST_CLR_ADDR && !evt_in.bcast |-> ##2 !raw_irq_status_out[11]; endproperty
  a_bcast_clr: assert property (p_bcast_clr) else $error("broadcast flag kept");
  property p_busy_hold;
    bus_in.rd && bus_in.addr == BUS_BUSY_CLR_ADDR && core_in.mst_active |-> ##2 raw_irq_status_out[8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped while active");
  property p_busy_read;
    bus_in.rd && bus_in.addr == BUS_BUSY_CLR_ADDR |=> rdata_out == {15'h0, raw_irq_status_out[8]}; endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy clear read data");
  property p_busy_auto;
    (!ctrl_enable_out && !core_in.mst_active && !core_in.slv_active) [*5] |-> !raw_irq_status_out[8]; endproperty
  a_busy_auto: assert property (p_busy_auto) else $error("busy flag not self cleared");
  property p_en_lag;
    bus_in.wr && bus_in.addr == ON_OFF_ADDR |-> ##3 ctrl_enable_out == $past(bus_in.wdata[0], 3); endproperty
  a_en_lag: assert property (p_en_lag) else $error("enable delay");
  property p_rx_flush;
    rx_flush_out == !ctrl_enable_out; endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("receive flush");
  property p_tx_end;
    stop_after_xfer_out && core_in.xfer_done |-> ##[1:2] tx_flush_out; endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit drain end");
  property p_rx_end;
    nack_next_out && core_in.byte_done |-> ##[1:2] !nack_next_out; endproperty
  a_rx_end: assert property (p_rx_end) else $error("receive drain end");
endmodule

bind i2cic_top i2cic_monitor i2cic_monitor_inst (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .evt_in(evt_in), .core_in(core_in), .raw_irq_status_out(raw_irq_status_out),
  .ctrl_enable_out(ctrl_enable_out), .tx_flush_out(tx_flush_out), .rx_flush_out(rx_flush_out),
  .stop_after_xfer_out(stop_after_xfer_out), .nack_next_out(nack_next_out));

// *** i2cic_core_model.sv ***
// behavioural core and remote bus partner giving activity and completion pulses
`timescale 1ns/1ps
module i2cic_core_model
  import i2cic_pkg::*;
(
  input wire logic clk_in,
  input wire logic [1:0] job_in,
  input wire logic [3:0] lag_in,
  input wire logic stop_after_xfer_in,
  input wire logic nack_next_in,
  output i2cic_core_t core_out
);
  // ----------------------------------------------------------------
  // transfer in progress
  // ----------------------------------------------------------------
  logic [3:0] cnt_reg = 4'h0;
  logic done_reg = 1'b0;
  logic xd_reg = 1'b0;
  logic bd_reg = 1'b0;
  logic hit;
  assign hit = cnt_reg == lag_in;
  // a drain request ends the unit in progress lag_in + 1 cycles later
  always_ff @(posedge clk_in) begin
    xd_reg <= 1'b0;
    bd_reg <= 1'b0;
    if (job_in == 2'h0) begin
      done_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (!done_reg && (stop_after_xfer_in || nack_next_in)) begin
      cnt_reg <= cnt_reg + 4'h1;
      done_reg <= hit;
      xd_reg <= hit && job_in[0];
      bd_reg <= hit && job_in[1];
    end
  end
  // job 01 is a master transmit, job 10 a slave receive
  assign core_out = '{mst_active: job_in[0] && !done_reg, slv_active: job_in[1] && !done_reg,
    tx_busy: job_in[0] && !done_reg, rx_busy: job_in[1] && !done_reg, xfer_done: xd_reg, byte_done: bd_reg};
endmodule

// *** testbench.sv ***
// self-checking bench for the interrupt-clear and controller-enable block
`timescale 1ns/1ps
module testbench;
  import i2cic_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  i2cic_bus_t bus = '0;
  i2cic_evt_t evt = '0;
  i2cic_core_t core;
  logic [1:0] job = 2'h0;
  logic [3:0] lag = 4'h0;
  logic [15:0] rdata_out, raw, msk, q;
  logic en, txf, rxf, stp, nak, irq;
  int n_fail = 0;
  int n_checks = 0;
  always #5 clk_in = ~clk_in;
  i2cic_top i2cic_top_inst (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata_out),
    .evt_in(evt), .core_in(core), .raw_irq_status_out(raw), .masked_irq_status_out(msk),
    .ctrl_enable_out(en), .tx_flush_out(txf), .rx_flush_out(rxf), .stop_after_xfer_out(stp),
    .nack_next_out(nak), .irq_out(irq));
  i2cic_core_model i2cic_core_model_inst (.clk_in(clk_in), .job_in(job), .lag_in(lag),
    .stop_after_xfer_in(stp), .nack_next_in(nak), .core_out(core));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1 q = rdata_out;
  endtask
  task automatic fire(input i2cic_evt_t e);
    @(posedge clk_in);
    evt <= e;
    @(posedge clk_in);
    evt <= '0;
    #1;
  endtask
  task automatic set_job(input logic [1:0] j);
    @(posedge clk_in);
    job <= j;
    step(2);
  endtask
  // bounded wait for stop (0), nack (1) or transmit flush (2) to reach v
  task automatic await(input int k, input logic v);
    int i;
    for (i = 0; i < 40 && (k == 0 ? stp : k == 1 ? nak : txf) !== v; i++) begin
      step(1);
    end
    if (i == 40) begin
      n_fail++;
      close_out();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] regs [7] = '{RX_DONE_CLR_ADDR, BUS_BUSY_CLR_ADDR, STOP_DET_CLR_ADDR, START_SEEN_FLAG_CLR_ADDR,
      BCAST_CLR_ADDR, ON_OFF_ADDR, 32'h5000_1300};
    chk({13'h0, en, txf, rxf}, 16'h0003);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(q, REG_RESET);
    end
    $display("reset values done");
  endtask
  task automatic t_clear();
    logic [31:0] adr [4] = '{RX_DONE_CLR_ADDR, STOP_DET_CLR_ADDR, START_SEEN_FLAG_CLR_ADDR, BCAST_CLR_ADDR};
    int bits [4] = '{RX_DONE_BIT, STOP_DET_BIT, START_SEEN_FLAG_BIT, BCAST_BIT};
    for (int k = 0; k < 4; k++) begin
      fire(i2cic_evt_t'(4'h8 >> k));
      step(1);
      chk(raw, 16'h1 << bits[k]);
      rd(adr[k]);
      chk(q, 16'h0001);
      step(1);
      chk(raw | rdata_out, 16'h0000);
    end
    $display("clear registers done");
  endtask
  task automatic t_irq();
    chk({15'h0, irq}, 16'h0000);
    wr(IRQ_MASK_ADDR, 16'h0001);
    step(1);
    chk({15'h0, irq}, 16'h0001);
    wr(IRQ_PEND_ADDR, 16'h0001);
    step(1);
    chk({15'h0, irq}, 16'h0000);
    rd(IRQ_PEND_ADDR);
    chk(q, 16'h001c);
    $display("interrupt done");
  endtask
  task automatic t_tx();
    wr(ON_OFF_ADDR, 16'h0001);
    chk({14'h0, en, rxf}, 16'h0001);
    step(2);
    chk({14'h0, en, rxf}, 16'h0002);
    step(1);
    chk({15'h0, txf}, 16'h0000);
    wr(IRQ_MASK_ADDR, 16'h0002);
    lag = 4'h6;
    set_job(2'h1);
    rd(BUS_BUSY_CLR_ADDR);
    chk(q, 16'h0001);
    step(1);
    chk({irq, raw[14:0]}, 16'h8100);
    rd(RAW_STAT_ADDR);
    chk(q, 16'h0100);
    rd(MASKED_STAT_ADDR);
    chk(q, 16'h0100);
    rd(ON_OFF_ADDR);
    chk(q, 16'h0001);
    wr(ON_OFF_ADDR, 16'h0000);
    await(0, 1'b1);
    chk({msk[8], txf, 14'h0}, 16'h8000);
    await(0, 1'b0);
    await(2, 1'b1);
    set_job(2'h0);
    step(4);
    chk({msk[8], raw[8]}, 16'h0000);
    rd(BUS_BUSY_CLR_ADDR);
    chk(q, 16'h0000);
    $display("transmit disable done");
  endtask
  task automatic t_rx();
    wr(ON_OFF_ADDR, 16'h0001);
    lag = 4'h0;
    set_job(2'h2);
    wr(ON_OFF_ADDR, 16'h0000);
    await(1, 1'b1);
    chk({14'h0, rxf, stp}, 16'h0002);
    await(1, 1'b0);
    set_job(2'h0);
    step(6);
    chk(raw, 16'h0000);
    wr(IRQ_PEND_ADDR, 16'h001f);
    step(1);
    chk({15'h0, irq}, 16'h0000);
    $display("receive disable done");
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    step(3);
    t_reset();
    t_clear();
    t_irq();
    t_tx();
    t_rx();
    close_out();
  end
endmodule
